// ### core/ioc_regs.svh
// Constants for the per-pin I/O cell: reset values, synchroniser depth, soft start hold.
// Assumes inclusion by bare name from files under core/.
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// Synchroniser depth for pad and clock pins
`define IOC_SYNC_STAGES   3
// Value every flop except init_q holds while rst is asserted
`define IOC_RST_BIT       1'b0
// Init flag value during rst: configured init is loaded after release
`define IOC_INIT_PENDING  1'b1
// Cycles of forced slow slew after the first output activation
`define IOC_SOFT_CYCLES   4'h1
`define IOC_SOFT_W        4

`endif

// ### core/ioc_pkg.sv
// Types for the per-pin I/O cell: mode enumerations and the configuration carrier.
// Assumes nothing; imported whole by every cell module.
package ioc_pkg;

	typedef enum logic [2:0] {
		IOC_IN_DIRECT      = 3'b000,
		IOC_IN_FLOP        = 3'b001,
		IOC_IN_LATCH       = 3'b010,
		IOC_IN_LATCH_FLOP  = 3'b011,
		IOC_IN_LATCH_LATCH = 3'b100
	} ioc_in_mode_t;

	typedef enum logic [1:0] {
		IOC_OUT_DIRECT = 2'b00,
		IOC_OUT_FLOP   = 2'b01,
		IOC_OUT_MUX    = 2'b10,
		IOC_OUT_FUNC   = 2'b11
	} ioc_out_mode_t;

	typedef enum logic [1:0] {
		IOC_FN_PASS = 2'b00,
		IOC_FN_AND  = 2'b01,
		IOC_FN_OR   = 2'b10,
		IOC_FN_XOR  = 2'b11
	} ioc_fn_op_t;

	typedef enum logic [1:0] {
		IOC_CE_INPUT  = 2'b00,
		IOC_CE_OUTPUT = 2'b01,
		IOC_CE_BOTH   = 2'b10
	} ioc_ce_target_t;

	typedef enum logic [1:0] {
		IOC_UNUSED_PULLUP   = 2'b00,
		IOC_UNUSED_PULLDOWN = 2'b01,
		IOC_UNUSED_DRIVEN   = 2'b10,
		IOC_UNUSED_EXTERNAL = 2'b11
	} ioc_unused_t;

	typedef struct packed {
		ioc_in_mode_t   in_mode;
		ioc_out_mode_t  out_mode;
		ioc_fn_op_t     fn_op;
		logic           fn_inv_data;
		logic           fn_inv_fast;
		ioc_ce_target_t ce_target;
		logic           inv_input_clock;
		logic           inv_capture_clock;
		logic           inv_output_clock;
		logic           inv_out_data;
		logic           inv_tri;
		logic           tri_registered;
		logic           fast_slew;
		ioc_unused_t    unused_mode;
		logic           in_init_set;
		logic           out_init_set;
		logic           tri_init_set;
	} ioc_cfg_t;

endpackage : ioc_pkg

// ### core/ioc_sync.sv
// Three-stage pin synchroniser; a new level is taken once stages two and three agree.
// Assumes a single clock; inputs may change at any time.
`timescale 1ns/1ps
`include "ioc_regs.svh"

module ioc_sync
	import ioc_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [`IOC_SYNC_STAGES-1:0] stage_q [WIDTH];

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// First stage feeds only the second stage
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					stage_q[g] <= '0;
				end else begin
					stage_q[g] <= {stage_q[g][`IOC_SYNC_STAGES-2:0], async_in[g]};
				end
			end

			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					sync_out[g] <= `IOC_RST_BIT;
				end else if (stage_q[g][1] == stage_q[g][2]) begin
					sync_out[g] <= stage_q[g][2];
				end
			end
		end
	endgenerate

endmodule : ioc_sync

// ### core/ioc_ofunc.sv
// Output multiplexer / two-input function generator of the cell.
// Assumes the fast input is the synchronised output-clock pin level.
`timescale 1ns/1ps

module ioc_ofunc
	import ioc_pkg::*;
(
	input  wire logic          mux_mode,
	input  ioc_fn_op_t         fn_op,
	input  wire logic          inv_data,
	input  wire logic          inv_fast,
	input  wire logic          data_a,
	input  wire logic          data_b,
	input  wire logic          fast_in,
	output logic               result
);

	function automatic logic gate_eval(input ioc_fn_op_t op, input logic a, input logic f);
		logic r;
		r = a;
		unique case (op)
			IOC_FN_PASS: r = a;
			IOC_FN_AND:  r = a & f;
			IOC_FN_OR:   r = a | f;
			IOC_FN_XOR:  r = a ^ f;
		endcase
		return r;
	endfunction : gate_eval

	logic a_pol;
	logic f_pol;

	always_comb begin
		a_pol = data_a ^ inv_data;
		f_pol = fast_in ^ inv_fast;
		if (mux_mode) begin
			result = fast_in ? data_b : data_a;
		end else begin
			result = gate_eval(fn_op, a_pol, f_pol);
		end
	end

endmodule : ioc_ofunc

// ### core/ioc_cell.sv
// Per-pin I/O cell: input capture, output register path, three-state control, slew and pulls.
// Assumes cell clocks arrive as pins sampled by the single system clock; config is static.
`timescale 1ns/1ps
`include "ioc_regs.svh"

module ioc_cell
	import ioc_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	input  ioc_cfg_t  cfg,
	input  wire logic global_set_reset,
	input  wire logic input_clock,
	input  wire logic output_clock,
	input  wire logic clock_enable_shared,
	input  wire logic out_data,
	input  wire logic out_data_alt,
	input  wire logic tri_ctrl,
	input  wire logic pad_unused,
	input  wire logic pad_in,
	output logic      pad_out,
	output logic      pad_oe,
	output logic      slew_fast,
	output logic      pull_up_en,
	output logic      pull_down_en,
	output logic      in_direct,
	output logic      in_registered
);

	// Pin-side synchronisation
	logic pad_s;
	logic ik_s;
	logic ok_s;

	ioc_sync #(
		.WIDTH(3)
	) u_sync (
		.clock   (clock),
		.rst     (rst),
		.async_in({pad_in, input_clock, output_clock}),
		.sync_out({pad_s, ik_s, ok_s})
	);

	// Init sequencing
	logic init_q;
	logic load_init;

	// Configured init values cannot enter the async reset, so they load on the first edge after release
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			init_q <= `IOC_INIT_PENDING;
		end else begin
			init_q <= `IOC_RST_BIT;
		end
	end

	assign load_init = init_q | global_set_reset;

	// Clock levels and edges
	logic ik_lvl;
	logic ok_lvl;
	logic cap_lvl;
	logic ik_prev_q;
	logic ok_prev_q;
	logic ik_rise;
	logic ok_rise;

	assign ik_lvl = ik_s ^ cfg.inv_input_clock;
	assign ok_lvl = ok_s ^ cfg.inv_output_clock;
	assign cap_lvl = ok_s ^ cfg.inv_capture_clock;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ik_prev_q <= `IOC_RST_BIT;
			ok_prev_q <= `IOC_RST_BIT;
		end else begin
			ik_prev_q <= ik_lvl;
			ok_prev_q <= ok_lvl;
		end
	end

	assign ik_rise = ik_lvl & ~ik_prev_q;
	assign ok_rise = ok_lvl & ~ok_prev_q;

	// Shared clock enable
	logic ce_in;
	logic ce_out;

	always_comb begin
		ce_in  = 1'b1;
		ce_out = 1'b1;
		unique case (cfg.ce_target)
			IOC_CE_INPUT:  ce_in = clock_enable_shared;
			IOC_CE_OUTPUT: ce_out = clock_enable_shared;
			IOC_CE_BOTH: begin
				ce_in  = clock_enable_shared;
				ce_out = clock_enable_shared;
			end
			default: begin
				ce_in  = 1'b1;
				ce_out = 1'b1;
			end
		endcase
	end

	// Input capture path
	logic use_fast_latch;
	logic in_is_latch;
	logic fast_q;
	logic cap_src;
	logic in_q;

	// Mode decoders for the capture registers; the bypass decoder is also used by the input output stage
	function automatic logic mode_has_fast_latch(input ioc_in_mode_t m);
		logic r;
		r = 1'b0;
		unique case (m)
			IOC_IN_LATCH_FLOP:  r = 1'b1;
			IOC_IN_LATCH_LATCH: r = 1'b1;
			default:            r = 1'b0;
		endcase
		return r;
	endfunction : mode_has_fast_latch

	function automatic logic mode_is_latch(input ioc_in_mode_t m);
		logic r;
		r = 1'b0;
		unique case (m)
			IOC_IN_LATCH:       r = 1'b1;
			IOC_IN_LATCH_LATCH: r = 1'b1;
			default:            r = 1'b0;
		endcase
		return r;
	endfunction : mode_is_latch

	// Unused codes fall back to bypass so in_registered follows the pad, not the held register
	function automatic logic mode_is_bypass(input ioc_in_mode_t m);
		return (m == IOC_IN_DIRECT) || (m > IOC_IN_LATCH_LATCH);
	endfunction : mode_is_bypass

	assign use_fast_latch = mode_has_fast_latch(cfg.in_mode);
	assign in_is_latch    = mode_is_latch(cfg.in_mode);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fast_q <= `IOC_RST_BIT;
		end else if (load_init) begin
			fast_q <= cfg.in_init_set;
		end else if (use_fast_latch && !cap_lvl) begin
			// Transparent while its clock is low
			fast_q <= pad_s;
		end
	end

	assign cap_src = use_fast_latch ? fast_q : pad_s;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_q <= `IOC_RST_BIT;
		end else if (load_init) begin
			in_q <= cfg.in_init_set;
		end else if (!mode_is_bypass(cfg.in_mode) && ce_in) begin
			if (in_is_latch) begin
				if (ik_lvl) begin
					in_q <= cap_src;
				end
			end else begin
				if (ik_rise) begin
					in_q <= cap_src;
				end
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_direct     <= `IOC_RST_BIT;
			in_registered <= `IOC_RST_BIT;
		end else begin
			in_direct     <= pad_s;
			in_registered <= mode_is_bypass(cfg.in_mode) ? pad_s : in_q;
		end
	end

	// Output data path
	logic data_pol;
	logic out_q;
	logic fn_result;
	logic data_sel;

	assign data_pol = out_data ^ cfg.inv_out_data;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_q <= `IOC_RST_BIT;
		end else if (load_init) begin
			out_q <= cfg.out_init_set;
		end else if (ok_rise && ce_out) begin
			out_q <= data_pol;
		end
	end

	ioc_ofunc u_ofunc (
		.mux_mode(cfg.out_mode == IOC_OUT_MUX),
		.fn_op   (cfg.fn_op),
		.inv_data(cfg.fn_inv_data),
		.inv_fast(cfg.fn_inv_fast),
		.data_a  (data_pol),
		.data_b  (out_data_alt),
		.fast_in (ok_s),
		.result  (fn_result)
	);

	always_comb begin
		data_sel = data_pol;
		unique case (cfg.out_mode)
			IOC_OUT_DIRECT: data_sel = data_pol;
			IOC_OUT_FLOP:   data_sel = out_q;
			IOC_OUT_MUX:    data_sel = fn_result;
			IOC_OUT_FUNC:   data_sel = fn_result;
		endcase
	end

	// Three-state path
	logic tri_pol;
	logic tri_q;
	logic tri_eff;
	logic drive;

	assign tri_pol = tri_ctrl ^ cfg.inv_tri;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tri_q <= `IOC_RST_BIT;
		end else if (load_init) begin
			tri_q <= cfg.tri_init_set;
		end else if (ok_rise && ce_out) begin
			tri_q <= tri_pol;
		end
	end

	assign tri_eff = cfg.tri_registered ? tri_q : tri_pol;

	// open drain needs no logic here: fabric wires tri to data
	assign drive = ~tri_eff;

	// Soft start-up
	logic       first_seen_q;
	logic [`IOC_SOFT_W-1:0] soft_cnt_q;
	logic       soft_done;

	assign soft_done = first_seen_q && (soft_cnt_q == '0);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			first_seen_q <= `IOC_RST_BIT;
			soft_cnt_q   <= '0;
		end else if (!first_seen_q && pad_oe) begin
			first_seen_q <= 1'b1;
			soft_cnt_q   <= `IOC_SOFT_CYCLES - `IOC_SOFT_W'(1);
		end else if (soft_cnt_q != '0) begin
			soft_cnt_q <= soft_cnt_q - `IOC_SOFT_W'(1);
		end
	end

	// Pad drive, pulls and slew
	logic pad_out_d;
	logic pad_oe_d;
	logic pu_d;
	logic pd_d;

	always_comb begin
		pad_out_d = data_sel;
		pad_oe_d  = drive;
		pu_d      = 1'b0;
		pd_d      = 1'b0;
		if (pad_unused) begin
			pad_out_d = 1'b0;
			pad_oe_d  = 1'b0;
			unique case (cfg.unused_mode)
				IOC_UNUSED_PULLUP:   pu_d = 1'b1;
				IOC_UNUSED_PULLDOWN: pd_d = 1'b1;
				IOC_UNUSED_DRIVEN:   pad_oe_d = 1'b1;
				IOC_UNUSED_EXTERNAL: pad_oe_d = 1'b0;
			endcase
		end
	end

	// Pad outputs held released until configured init has loaded
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pad_out      <= `IOC_RST_BIT;
			pad_oe       <= `IOC_RST_BIT;
			pull_up_en   <= `IOC_RST_BIT;
			pull_down_en <= `IOC_RST_BIT;
			slew_fast    <= `IOC_RST_BIT;
		end else begin
			pad_out      <= init_q ? `IOC_RST_BIT : pad_out_d;
			pad_oe       <= init_q ? `IOC_RST_BIT : pad_oe_d;
			pull_up_en   <= pu_d;
			pull_down_en <= pd_d;
			slew_fast    <= cfg.fast_slew && soft_done;
		end
	end

endmodule : ioc_cell

// ### tb/ioc_pad_model.sv
// Pad and board model: resolves the level the cell sees on its pad input.
// Assumes the bench drives ext_en/ext_val in place of an external source.
`timescale 1ns/1ps
module ioc_pad_model (
	input  wire logic clock,
	input  wire logic pad_out,
	input  wire logic pad_oe,
	input  wire logic pull_up_en,
	input  wire logic pull_down_en,
	input  wire logic ext_en,
	input  wire logic ext_val,
	output logic      pad_in
);
	logic flip_q = 1'b0;
	always_ff @(posedge clock) begin
		flip_q <= ~flip_q;
	end
	always_comb begin
		if (pad_oe)
			pad_in = pad_out;
		else if (ext_en)
			pad_in = ext_val;
		else if (pull_up_en || pull_down_en)
			pad_in = pull_up_en;
		else
			// Floating pad toggles so a stale level is never mistaken for data
			pad_in = flip_q;
	end
endmodule : ioc_pad_model

// ### tb/ioc_cell_props.sv
// Checker for the output side of the I/O cell, bound to ioc_cell.
// Assumes cfg only changes under rst or where the guarded modes are not in use.
`timescale 1ns/1ps
module ioc_cell_props
	import ioc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input ioc_cfg_t  cfg,
	input wire logic global_set_reset,
	input wire logic output_clock,
	input wire logic clock_enable_shared,
	input wire logic out_data,
	input wire logic out_data_alt,
	input wire logic tri_ctrl,
	input wire logic pad_unused,
	input wire logic pad_out,
	input wire logic pad_oe,
	input wire logic slew_fast,
	input wire logic pull_up_en,
	input wire logic pull_down_en
);
	logic       ok_q;
	logic       exp_q;
	logic [1:0] age_q;
	default clocking dc @(posedge clock); endclocking
	default disable iff (rst);
	// ok_q masks the first edge after release, where the pad is forced low
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ok_q  <= 1'b0;
			exp_q <= 1'b0;
			age_q <= 2'h0;
		end else begin
			ok_q  <= 1'b1;
			exp_q <= (cfg.out_mode == IOC_OUT_MUX && output_clock) ? out_data_alt : out_data ^ cfg.inv_out_data;
			if ((pad_oe || age_q != 2'h0) && age_q != 2'h3)
				age_q <= age_q + 2'h1;
		end
	end
	chk_tri_release: assert property ((tri_ctrl ^ cfg.inv_tri) && !cfg.tri_registered && !pad_unused |=> !pad_oe)
		else $error("pad driven while released");
	chk_tri_drive: assert property (ok_q && !(tri_ctrl ^ cfg.inv_tri) && !cfg.tri_registered && !pad_unused |=> pad_oe)
		else $error("pad not driven");
	chk_unused_pull: assert property (ok_q && pad_unused && cfg.unused_mode == IOC_UNUSED_PULLUP |=>
		pull_up_en && !pull_down_en && !pad_oe) else $error("unused pad not pulled up");
	chk_unused_drive: assert property (ok_q && pad_unused && cfg.unused_mode == IOC_UNUSED_DRIVEN |=>
		pad_oe && !pad_out) else $error("unused pad not driven low");
	chk_soft_start: assert property (age_q == 2'h0 |-> !slew_fast)
		else $error("fast slew before first activation");
	chk_slew_config: assert property (age_q == 2'h3 |-> slew_fast == cfg.fast_slew)
		else $error("slew differs from setting");
	chk_direct_path: assert property (ok_q && cfg.out_mode == IOC_OUT_DIRECT && !pad_unused |=> pad_out == exp_q)
		else $error("direct pad data wrong");
	chk_mux_select: assert property ((cfg.out_mode == IOC_OUT_MUX && !pad_unused && $stable(output_clock))[*5] |=>
		pad_out == exp_q) else $error("mux output wrong");
	chk_out_hold: assert property (ok_q && cfg.out_mode == IOC_OUT_FLOP && !global_set_reset && !clock_enable_shared
		&& cfg.ce_target inside {IOC_CE_OUTPUT, IOC_CE_BOTH} && !pad_unused ##1 !pad_unused |=> $stable(pad_out))
		else $error("output flop changed while disabled");
	chk_init_load: assert property (cfg.out_mode == IOC_OUT_FLOP && global_set_reset && !pad_unused ##1 !pad_unused
		|=> pad_out == cfg.out_init_set) else $error("output flop missed init value");
endmodule : ioc_cell_props

bind ioc_cell ioc_cell_props i_ioc_cell_props (.*);

// ### tb/io_cell_register_path_test.sv
// Self-checking bench for the I/O cell: random output data, modes, capture chain, unused pads.
// Assumes the checker is bound to ioc_cell and the pad model closes the pin loop.
`timescale 1ns/1ps
module io_cell_register_path_test;
	import ioc_pkg::*;
	logic clock = 1'b0, rst = 1'b1, grst = 1'b0, in_clk = 1'b0, out_clk = 1'b0, ce = 1'b1;
	logic od = 1'b0, oda = 1'b0, tri_c = 1'b0, unused = 1'b0, ext_en = 1'b0, ext_val = 1'b0;
	logic pad_in, pad_out, pad_oe, slew_fast, pull_up_en, pull_down_en, in_registered, v, pd, pt;
	ioc_cfg_t   cfg = '0;
	ioc_cfg_t   c;
	logic [7:0] lf = 8'h52;
	int         n_mismatch = 0;
	int         num_checks = 0;
	ioc_cell i_ioc_cell (.clock(clock), .rst(rst), .cfg(cfg), .global_set_reset(grst), .input_clock(in_clk),
		.output_clock(out_clk), .clock_enable_shared(ce), .out_data(od), .out_data_alt(oda), .tri_ctrl(tri_c),
		.pad_unused(unused), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .slew_fast(slew_fast),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .in_direct(), .in_registered(in_registered));
	ioc_pad_model i_ioc_pad_model (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
	always #5 clock = ~clock;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Pass is left unchecked: which input it forwards is not pinned down
	function automatic logic fn_exp(input ioc_fn_op_t op, input logic a, input logic b);
		case (op)
			IOC_FN_AND: return a & b;
			IOC_FN_OR:  return a | b;
			default:    return a ^ b;
		endcase
	endfunction : fn_exp
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %b, expected %b", $time, got, exp);
		end
	endtask : check_bit
	// Pins are parked at their idle level while reset is held, so no edge is seen on release
	task automatic restart(input ioc_cfg_t nc);
		@(posedge clock);
		rst <= 1'b1;
		cfg <= nc;
		in_clk <= nc.inv_input_clock;
		out_clk <= nc.inv_capture_clock;
		tick(1);
		rst <= 1'b0;
		tick(6);
	endtask : restart
	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		#50000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		tick(5);
		rst <= 1'b0;
		c = '0;
		c.inv_out_data = 1'b1;
		c.inv_tri = 1'b1;
		c.fast_slew = 1'b1;
		restart(c);
		for (int i = 0; i < 24; i++) begin
			od <= lf[0];
			tri_c <= lf[1];
			@(negedge clock);
			if (i > 0) begin
				check_bit(pad_out, ~pd);
				check_bit(pad_oe, pt);
			end
			pd = lf[0];
			pt = lf[1];
			lf = lfsr(lf);
			tick(1);
		end
		@(negedge clock);
		check_bit(slew_fast, 1'b1);
		$display("direct path test done");
		c = '0;
		c.out_mode = IOC_OUT_FUNC;
		c.fn_inv_data = lf[2];
		c.fn_inv_fast = lf[3];
		restart(c);
		tri_c <= 1'b0;
		for (int k = 0; k < 10; k++) begin
			v = lf[0];
			if (k < 8)
				cfg.fn_op <= ioc_fn_op_t'(k[2:1]);
			else
				cfg.out_mode <= IOC_OUT_MUX;
			out_clk <= k[0];
			od <= v;
			oda <= ~v;
			tick(6);
			@(negedge clock);
			if (k >= 8)
				check_bit(pad_out, k[0] ? ~v : v);
			else if (k > 1)
				check_bit(pad_out, fn_exp(ioc_fn_op_t'(k[2:1]), v ^ c.fn_inv_data, k[0] ^ c.fn_inv_fast));
			lf = lfsr(lf);
			tick(1);
		end
		@(negedge clock);
		check_bit(slew_fast, 1'b0);
		$display("function and mux test done");
		c = '0;
		c.out_mode = IOC_OUT_FLOP;
		c.ce_target = IOC_CE_OUTPUT;
		c.out_init_set = 1'b1;
		restart(c);
		@(negedge clock);
		check_bit(pad_out, 1'b1);
		tick(1);
		od <= 1'b0;
		out_clk <= 1'b1;
		tick(6);
		@(negedge clock);
		check_bit(pad_out, 1'b0);
		for (int k = 0; k < 3; k++) begin
			tick(1);
			out_clk <= 1'b0;
			cfg.ce_target <= ioc_ce_target_t'(k[1:0]);
			ce <= 1'b0;
			grst <= 1'b1;
			tick(1);
			grst <= 1'b0;
			tick(5);
			out_clk <= 1'b1;
			tick(6);
			@(negedge clock);
			check_bit(pad_out, k != 0);
		end
		$display("output flop test done");
		ce <= 1'b1;
		tri_c <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			c = '0;
			c.in_mode = ioc_in_mode_t'(3'(k % 4 + 1));
			c.inv_input_clock = k[2];
			c.inv_capture_clock = k[2];
			restart(c);
			v = lf[0];
			ext_en <= 1'b1;
			ext_val <= v;
			tick(6);
			out_clk <= ~k[2];
			tick(6);
			ext_val <= ~v;
			tick(6);
			in_clk <= ~k[2];
			tick(6);
			@(negedge clock);
			check_bit(in_registered, k[1] ? v : ~v);
			lf = lfsr(lf);
		end
		$display("input capture test done");
		c = '0;
		c.tri_registered = 1'b1;
		c.tri_init_set = 1'b1;
		restart(c);
		@(negedge clock);
		check_bit(pad_oe, 1'b0);
		tick(1);
		v = lf[0];
		od <= 1'b0;
		tri_c <= v;
		out_clk <= 1'b1;
		tick(6);
		@(negedge clock);
		check_bit(pad_oe, ~v);
		check_bit(pad_out, 1'b0);
		tick(1);
		tri_c <= ~v;
		tick(6);
		@(negedge clock);
		check_bit(pad_oe, ~v);
		lf = lfsr(lf);
		tick(1);
		$display("three-state register test done");
		restart('0);
		ext_en <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			cfg.unused_mode <= ioc_unused_t'(k[1:0]);
			unused <= 1'b1;
			tick(3);
			@(negedge clock);
			check_bit(pull_up_en, k == 0);
			check_bit(pull_down_en, k == 1);
			check_bit(pad_oe, k == 2);
			tick(1);
		end
		$display("unused pad test done");
		print_verdict();
	end
endmodule : io_cell_register_path_test
